// ==== pwo_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module pwo_top
   import pwo_pkg::*;
#(
   parameter logic [DIV_W-1:0] DIV_SLOW = PRESC_DIV_SLOW
) (
   input  wire logic              ref_clk, // System clock, 20 MHz
   input  wire logic              rst,     // Synchronous reset
   input  wire logic              psel,    // APB select
   input  wire logic              penable, // APB enable
   input  wire logic              pwrite,  // APB write
   input  wire logic [ADDR_W-1:0] paddr,   // APB byte address
   input  wire logic [31:0]       pwdata,  // APB write data
   output logic      [31:0]       prdata,  // APB read data
   output logic                   pready,  // APB ready
   output logic                   pslverr, // APB error, unmapped address
   output logic      [CH_N-1:0]   pwm_out  // Channel outputs
);

   typedef struct packed {
      logic [15:0]                 ctrl;
      logic [CNT_W-1:0]            maxc;
      logic [CH_N-1:0][CNT_W-1:0]  start;
      logic [CH_N-1:0][CNT_W-1:0]  stop;
      logic [15:0]                 cyc;
      logic [CNT_W-1:0]            cnt;
      logic [CNT_W-1:0]            wins;
      pwo_state_e                  st;
      logic [CH_N-1:0]             out;
      logic [31:0]                 prdata;
      logic                        pready;
      logic                        pslverr;
   } pwo_top_s;

   pwo_top_s q;
   pwo_top_s nx;
   logic     tick;
   logic [3:0] code;
   logic [2:0] pos_idx;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] reg_code(input logic [ADDR_W-1:0] a);
      logic [15:0] idx;
      logic [15:0] rel;
      idx = a[ADDR_W-1:2];
      rel = idx - IDX_CTRL;
      if (a[1:0] != 2'b00 || idx < IDX_CTRL || idx > IDX_CYC || rel[0]) begin
         return REG_NONE;
      end
      return rel[4:1];
   endfunction

   function automatic logic win_on(input logic [CNT_W-1:0] s, input logic [CNT_W-1:0] e,
                                   input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] m,
                                   input logic running);
      if (e > m) begin
         return 1'b1;
      end
      return running && c >= s && c < e;
   endfunction

   // ---------------------------------------------------------------
   // Tick divider
   // ---------------------------------------------------------------
   pwo_prescaler #(
      .DIV_SLOW (DIV_SLOW)
   ) u_presc (
      .ref_clk (ref_clk),
      .rst     (rst),
      .run     (q.st == ST_RUN),
      .sel     (q.ctrl[CTRL_PRE_LSB +: 3]),
      .tick    (tick)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nx      = q;
      code    = reg_code(paddr);
      pos_idx = 3'(code - REG_START);
      nx.pready = 1'b0;

      // Bus slave: answer in the access cycle, zero wait states
      if (psel && !penable) begin
         nx.pready  = 1'b1;
         nx.pslverr = (code == REG_NONE);
         nx.prdata  = '0;
         case (code)
            REG_CTRL: begin
               nx.prdata[15:0] = q.ctrl;
            end
            REG_MAXC: begin
               nx.prdata[CNT_W-1:0] = q.maxc;
            end
            REG_CYC: begin
               nx.prdata[15:0] = q.cyc;
            end
            REG_NONE: begin
               nx.prdata = '0;
            end
            default: begin
               nx.prdata[CNT_W-1:0] = pos_idx[0] ? q.stop[pos_idx[2:1]] : q.start[pos_idx[2:1]];
            end
         endcase
      end

      if (psel && penable && q.pready && pwrite) begin
         case (code)
            REG_CTRL: begin
               nx.ctrl = pwdata[15:0] & CTRL_RW_MASK;
            end
            REG_MAXC: begin
               nx.maxc = pwdata[CNT_W-1:0];
            end
            REG_CYC: begin
               nx.cyc = pwdata[15:0];
            end
            REG_NONE: begin
               nx.cyc = q.cyc;
            end
            default: begin
               // Upper position bits are not stored
               if (pos_idx[0]) begin
                  nx.stop[pos_idx[2:1]] = pwdata[CNT_W-1:0];
               end else begin
                  nx.start[pos_idx[2:1]] = pwdata[CNT_W-1:0];
               end
            end
         endcase
      end

      // Window sequencer
      case (q.st)
         ST_IDLE: begin
            nx.cnt  = '0;
            nx.wins = '0;
            if (q.ctrl[CTRL_RUN_BIT]) begin
               nx.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!q.ctrl[CTRL_RUN_BIT]) begin
               nx.st = ST_IDLE;
            end else if (tick) begin
               if (q.cnt >= q.maxc) begin
                  nx.cnt = '0;
                  if (q.ctrl[CTRL_MODE_BIT]) begin
                     if (q.wins == q.cyc[CNT_W-1:0]) begin
                        nx.st = ST_DONE;
                     end else begin
                        nx.wins = q.wins + 10'h001;
                     end
                  end else begin
                     nx.wins = '0;
                  end
               end else begin
                  nx.cnt = q.cnt + 10'h001;
               end
            end
         end
         ST_DONE: begin
            if (!q.ctrl[CTRL_RUN_BIT]) begin
               nx.st = ST_IDLE;
            end
         end
         default: begin
            nx.st = ST_IDLE;
         end
      endcase

      // Channel outputs; equal start and stop force zero, otherwise a disabled channel rests at its idle level
      for (int i = 0; i < CH_N; i++) begin
         if (q.start[i] == q.stop[i]) begin
            nx.out[i] = 1'b0;
         end else if (q.ctrl[CTRL_EN_LSB + i]) begin
            nx.out[i] = !(win_on(q.start[i], q.stop[i], q.cnt, q.maxc, q.st == ST_RUN)
                          ^ q.ctrl[CTRL_POL_LSB + i]);
         end else begin
            nx.out[i] = !q.ctrl[CTRL_POL_LSB + i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q       <= '0;
         q.ctrl  <= CTRL_RST;
         q.cyc   <= CYC_RST;
         q.start <= {CH_N{POS_RST}};
         q.stop  <= {CH_N{POS_RST}};
         q.st    <= ST_IDLE;
      end else begin
         q <= nx;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;
   assign pwm_out = q.out;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   stop_end_a: assert property (q.st == ST_RUN && q.ctrl[0] && q.start[0] < q.stop[0]
      && q.stop[0] <= q.maxc && q.cnt == q.stop[0] |=> pwm_out[0] == !$past(q.ctrl[4]))
      else $error("channel 0 still asserted at its stop position");
   equal_zero_a: assert property (q.start[1] == q.stop[1] |=> pwm_out[1] == 1'b0)
      else $error("equal start and stop did not force zero");
   stop_over_a: assert property (q.ctrl[2] && q.start[2] != q.stop[2] && q.stop[2] > q.maxc
      |=> pwm_out[2] == $past(q.ctrl[6]))
      else $error("stop beyond window did not hold asserted level");
   oneshot_mode_a: assert property ($rose(q.st == ST_DONE) |-> $past(q.ctrl[CTRL_MODE_BIT]))
      else $error("one-shot finish without mode bit");
   window_count_a: assert property ($rose(q.st == ST_DONE) |-> $past(q.wins) == $past(q.cyc[9:0]))
      else $error("one-shot stopped at wrong window count");
   cont_wrap_a: assert property (q.st == ST_RUN && q.ctrl[15] && !q.ctrl[8] && tick
      && q.cnt >= q.maxc |=> q.cnt == 10'h000 && q.st == ST_RUN)
      else $error("continuous mode did not restart the window");
   run_stop_a: assert property (!q.ctrl[CTRL_RUN_BIT] |=> ##1 q.cnt == 10'h000)
      else $error("counter not cleared after stop");
   count_step_a: assert property (q.st == ST_RUN && q.ctrl[15] && tick && q.cnt < q.maxc
      |=> q.cnt == $past(q.cnt) + 10'h001)
      else $error("window counter did not advance on tick");
   polarity_idle_a: assert property (!q.ctrl[3] && q.start[3] != q.stop[3]
      |=> pwm_out[3] == !$past(q.ctrl[7]))
      else $error("disabled channel not at idle level");

endmodule
`default_nettype wire

// ==== pwo_pkg.sv ====
`default_nettype none
package pwo_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int CH_N   = 4;
   localparam int CNT_W  = 10;
   localparam int ADDR_W = 18;
   localparam int DIV_W  = 14;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [15:0] IDX_CTRL   = 16'hc0e6;
   localparam logic [15:0] IDX_MAXC   = 16'hc0e8;
   localparam logic [15:0] IDX_START0 = 16'hc0ea;
   localparam logic [15:0] IDX_STOP0  = 16'hc0ec;
   localparam logic [15:0] IDX_CYC    = 16'hc0fa;

   // Decoded register codes: starts and stops interleave from 2 up
   localparam logic [3:0] REG_CTRL  = 4'h0;
   localparam logic [3:0] REG_MAXC  = 4'h1;
   localparam logic [3:0] REG_START = 4'h2;
   localparam logic [3:0] REG_CYC   = 4'ha;
   localparam logic [3:0] REG_NONE  = 4'hf;

   // ---------------------------------------------------------------
   // Control fields and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_RUN_BIT  = 15;
   localparam int CTRL_PRE_LSB  = 9;
   localparam int CTRL_MODE_BIT = 8;
   localparam int CTRL_POL_LSB  = 4;
   localparam int CTRL_EN_LSB   = 0;
   localparam logic [15:0] CTRL_RW_MASK = 16'h8fff;
   localparam logic [15:0] CTRL_RST     = 16'h0000;
   localparam logic [15:0] CYC_RST      = 16'h0000;
   localparam logic [9:0]  POS_RST      = 10'h000;

   // ---------------------------------------------------------------
   // Prescale divisors per select code 0..6 (code 7 is a parameter)
   // ---------------------------------------------------------------
   localparam logic [6:0][DIV_W-1:0] PRESC_DIV = {14'h0800, 14'h0200, 14'h0080, 14'h0020,
                                                 14'h0008, 14'h0002, 14'h0001};
   localparam logic [DIV_W-1:0] PRESC_DIV_SLOW = 14'h2000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_DONE = 2'b10
   } pwo_state_e;

endpackage
`default_nettype wire

// ==== pwo_prescaler.sv ====
`timescale 1ns/100ps
`default_nettype none
module pwo_prescaler
   import pwo_pkg::*;
#(
   parameter logic [DIV_W-1:0] DIV_SLOW = PRESC_DIV_SLOW
) (
   input  wire logic       ref_clk, // System clock
   input  wire logic       rst,     // Synchronous reset
   input  wire logic       run,     // Counting active
   input  wire logic [2:0] sel,     // Prescale select code
   output logic            tick     // One-cycle count enable
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } pwo_presc_s;

   pwo_presc_s q;
   pwo_presc_s nx;
   logic [DIV_W-1:0] div_last;

   always_comb begin
      div_last = ((sel == 3'h7) ? DIV_SLOW : PRESC_DIV[sel]) - 14'h0001;
      nx       = q;
      nx.tick  = 1'b0;
      if (!run) begin
         nx.cnt = '0;
      end else if (q.cnt >= div_last) begin
         nx.cnt  = '0;
         nx.tick = 1'b1;
      end else begin
         nx.cnt = q.cnt + 14'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= nx;
      end
   end

   assign tick = q.tick;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   fast_tick_a: assert property (run && $past(run) && sel == 3'h0 && $past(sel) == 3'h0 |-> tick)
      else $error("full-rate select did not tick every cycle");
   half_tick_a: assert property (tick && sel == 3'h1 && $past(sel) == 3'h1 && run |=> !tick)
      else $error("half-rate select ticked twice in a row");

endmodule
`default_nettype wire

// ==== pwo_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module pwo_top_tb
   import pwo_pkg::*;
;
   localparam int DIVS = 4;
   logic              ref_clk;
   logic              rst;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [CH_N-1:0]   pwm_out;
   int                mismatches;
   int                n_checks;
   logic [31:0]       rd;
   logic              err;
   int                hi[CH_N];
   int                rise;
   int                per;
   int                divs[8] = '{1, 2, 8, 32, 128, 512, 2048, DIVS};
   logic [31:0]       cfg[9] = '{32'h3, 32'h1, 32'h2, 32'h2, 32'h2, 32'h0, 32'h5, 32'h1, 32'h3};

   pwo_top #(.DIV_SLOW(DIV_W'(DIVS))) i_dut (
      .ref_clk (ref_clk),
      .rst     (rst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .pwm_out (pwm_out)
   );

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // ---------------------------------------------------------------
   // Bus and observation tasks
   // ---------------------------------------------------------------
   task automatic test_done();
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         test_done();
      end
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, e});
   endtask

   // Counts high samples per channel and rising edges of channel 0
   task automatic watch(input int n);
      logic [CH_N-1:0] last;
      #1;
      last = pwm_out;
      hi = '{default: 0};
      rise = 0;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         foreach (hi[c]) hi[c] += int'(pwm_out[c] === 1'b1);
         rise += int'(pwm_out[0] === 1'b1 && last[0] === 1'b0);
         last = pwm_out;
      end
   endtask

   task automatic next_rise(output int c);
      logic l;
      c = 0;
      #1;
      l = pwm_out[0];
      do begin
         @(posedge ref_clk);
         #1;
         c++;
         if (pwm_out[0] === 1'b1 && l === 1'b0) return;
         l = pwm_out[0];
      end while (c < 40000);
      mismatches++;
      test_done();
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int a;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      mismatches = 0;
      n_checks = 0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      for (a = 'h30398; a <= 'h303e8; a += 8) rdchk(ADDR_W'(a), 32'h0, 1'b0);
      rdchk(18'h303ec, 32'h0, 1'b1);
      apb(1'b1, 18'h30398, 32'hffff);
      rdchk(18'h30398, 32'h8fff, 1'b0);
      apb(1'b1, 18'h30398, 32'h0);
      for (a = 0; a < 4; a++) begin
         apb(1'b1, ADDR_W'('h303b0 + 16 * a), 32'h3ff);
         rdchk(ADDR_W'('h303b0 + 16 * a), 32'h3ff, 1'b0);
      end
      apb(1'b1, 18'h303e8, 32'hffff);
      rdchk(18'h303e8, 32'hffff, 1'b0);
      foreach (cfg[i]) apb(1'b1, ADDR_W'('h303a0 + 8 * i), cfg[i]);
      // Channel 3 disabled with low polarity, so it idles high
      apb(1'b1, 18'h30398, 32'h8077);
      repeat (4) @(posedge ref_clk);
      watch(40);
      chk(32'(hi[0]), 32'd10);
      chk(32'(hi[1]), 32'd0);
      chk(32'(hi[2]), 32'd40);
      chk(32'(hi[3]), 32'd40);
      chk(32'(rise), 32'd10);
      apb(1'b1, 18'h30398, 32'h8067);
      repeat (4) @(posedge ref_clk);
      watch(40);
      chk(32'(hi[0]), 32'd30);
      apb(1'b1, 18'h30398, 32'h0077);
      repeat (4) @(posedge ref_clk);
      watch(40);
      chk(32'(rise), 32'd0);
      chk(32'(hi[2]), 32'd40);
      for (a = 0; a < 3; a++) begin
         apb(1'b1, 18'h30398, 32'h0);
         apb(1'b1, 18'h303e8, 32'(a));
         apb(1'b1, 18'h30398, 32'h8177);
         watch(60);
         chk(32'(rise), 32'(a + 1));
      end
      // One-shot left the sequencer finished; the run bit must drop before a restart
      apb(1'b1, 18'h30398, 32'h0);
      for (a = 0; a < 8; a++) begin
         apb(1'b1, 18'h30398, 32'h8077 | 32'(a << 9));
         next_rise(per);
         next_rise(per);
         next_rise(per);
         chk(32'(per), 32'(4 * divs[a]));
      end
      test_done();
   end
endmodule
`default_nettype wire
